//--- core/occ_pkg.sv
// Purpose: Shared constants and types for the oscillator and
//          reference clock control block.
// Assumes: 32-bit AHB-Lite register bus, one clock.
// Notes:   Offsets and key values are local choices.
`default_nettype none

package occ_pkg;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses, low byte of HADDR)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_OSC = 8'h00;
  localparam logic [7:0] OFS_REF = 8'h04;
  localparam logic [7:0] OFS_KEY = 8'h08;
  localparam logic [7:0] OFS_IST = 8'h0C;
  localparam logic [7:0] OFS_IMSK = 8'h10;

  // ---------------------------------------------------------------
  // Oscillator control fields
  // ---------------------------------------------------------------
  localparam int OSC_SWREQ_B = 0;
  localparam int OSC_SOSC_B = 1;
  localparam int OSC_USBFRC_B = 2;
  localparam int OSC_CF_B = 3;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_CUR_LSB = 12;
  localparam int SEL_W = 3;
  localparam logic [2:0] CUR_OSC_RST = 3'h0;
  // Current-source codes that leave the output pin free
  localparam logic [7:0] PB_OUT_MODES = 8'h83;

  // ---------------------------------------------------------------
  // Reference clock control fields
  // ---------------------------------------------------------------
  localparam int REF_SEL_LSB = 0;
  localparam int REF_SEL_W = 4;
  localparam int REF_ACT_B = 8;
  localparam int REF_DSW_B = 9;
  localparam int REF_REFCLK_RUN_IN_SLEEP_B = 11;
  localparam int REF_OE_B = 12;
  localparam int REF_STOP_WHEN_IDLE_B = 13;
  localparam int REF_ON_B = 15;
  localparam int REF_DIV_LSB = 16;
  localparam int REF_DIV_W = 15;
  localparam logic [31:0] REF_WMASK = 32'h7FFF_BA0F;

  // ---------------------------------------------------------------
  // Unlock keys (values arbitrary) and interrupt bits
  // ---------------------------------------------------------------
  localparam logic [31:0] KEY1 = 32'h1234_5678;
  localparam logic [31:0] KEY2 = 32'h8765_4321;
  localparam int IRQ_W = 3;
  localparam int IRQ_CF_B = 0;
  localparam int IRQ_SW_B = 1;
  localparam int IRQ_DSW_B = 2;

  // Reference generator settings handed to the divider
  typedef struct packed {
    logic [REF_DIV_W-1:0] div;
    logic [REF_SEL_W-1:0] sel;
    logic on;
    logic run;
  } occ_ref_cfg_t;

endpackage
`default_nettype wire

//--- core/occ_unlock.sv
// Purpose: Two-key unlock sequence for the oscillator control register.
// Assumes: Key writes arrive as one-cycle strobes.
// Notes:   Unlock is consumed by the next control write.
`timescale 1ns/1ps
`default_nettype none

module occ_unlock
  import occ_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic key_wr,
  input wire logic [31:0] key_data,
  input wire logic consume,
  output logic unlocked
);

  // ---------------------------------------------------------------
  // Sequence state
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LOCKED = 3'b001,
    ST_HALF = 3'b010,
    ST_OPEN = 3'b100
  } occ_ulk_t;

  occ_ulk_t state_reg;
  occ_ulk_t state_next;

  // Any wrong key restarts, so a stray write cannot half-open it
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOCKED: if (key_wr && key_data == KEY1) state_next = ST_HALF;
      ST_HALF: if (key_wr) state_next = (key_data == KEY2) ? ST_OPEN : ST_LOCKED;
      ST_OPEN: if (consume || key_wr) state_next = ST_LOCKED;
      default: state_next = ST_LOCKED;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) state_reg <= ST_LOCKED;
    else state_reg <= state_next;
  end

  assign unlocked = (state_reg == ST_OPEN);

endmodule
`default_nettype wire

//--- core/occ_refdiv.sv
// Purpose: Reference clock divider on selected source tick enables.
// Assumes: Source ticks are one-cycle enables on the system clock.
// Notes:   Output toggles each div ticks; zero passes the source.
`timescale 1ns/1ps
`default_nettype none

module occ_refdiv
  import occ_pkg::*;
#(
  parameter int NSRC = 16
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire occ_ref_cfg_t cfg,
  input wire logic [NSRC-1:0] src_tick,
  output logic ref_clk
);

  // Elaboration check on source count
  if (NSRC != (1 << REF_SEL_W)) begin : g_chk
    $error("occ_refdiv: NSRC must match select width");
  end

  logic [REF_DIV_W-1:0] cnt_reg;
  logic tog_reg;
  wire tick = src_tick[cfg.sel];
  wire go = cfg.on && cfg.run && tick;
  wire wrap = (cnt_reg >= cfg.div - 15'd1);

  // Count ticks, toggle on wrap; held low while off
  always_ff @(posedge clk) begin
    if (!rst_n || !cfg.on) begin
      cnt_reg <= '0;
      tog_reg <= 1'b0;
    end else if (go) begin
      cnt_reg <= wrap ? '0 : cnt_reg + 15'd1;
      if (wrap) tog_reg <= ~tog_reg;
    end
  end

  // Divider zero forwards the selected source enable, gated by on and run
  assign ref_clk = (cfg.div == '0) ? go : tog_reg;

endmodule
`default_nettype wire

//--- core/occ_top.sv
// Purpose: Oscillator control, fail flag, switch handshake and
//          reference clock generator behind an AHB-Lite slave.
// Assumes: Single clock; all pins synchronous to it.
// Notes:   Zero wait states; read data registered.
//          Oscillator control writes need the two-key unlock first.
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module occ_top
  import occ_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic CLK_FAIL_DET,
  input wire logic SWITCH_ACK,
  output logic SWITCH_REQ,
  output logic [2:0] NEW_OSC,
  output logic SOSC_EN,
  output logic USB_FRC_SEL,
  input wire logic PERIPHERAL_BUS_CLOCK_TICK,
  output logic OSC_OUT,
  output logic OSC_OUT_OE,
  input wire logic [15:0] REF_SRC_TICK,
  input wire logic SLEEP,
  input wire logic IDLE,
  output logic REFCLK_OUT,
  output logic REFCLK_OE,
  output logic IRQ
);

  // ---------------------------------------------------------------
  // Bus address phase capture
  // ---------------------------------------------------------------
  // Valid transfer seen in the address phase
  wire addr_ok = HSEL && HREADY && HTRANS[1];
  // Full-word writes only; other write sizes are ignored, reads take any size
  wire word_sz = (HSIZE == 3'b010);

  logic wr_pend_reg; // Write waiting for its data phase
  logic [7:0] wr_addr_reg; // Captured write offset

  // Capture a write so its data can be taken next cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE && word_sz;
      if (addr_ok) wr_addr_reg <= HADDR[7:0];
    end
  end

  // ---------------------------------------------------------------
  // Write strobes
  // ---------------------------------------------------------------
  // Offset match, shared by the write strobes and the read mux
  function automatic logic ofs_hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // One strobe per register, high for the data phase only
  wire wr_osc = wr_pend_reg && ofs_hit(wr_addr_reg, OFS_OSC);
  wire wr_ref = wr_pend_reg && ofs_hit(wr_addr_reg, OFS_REF);
  wire wr_key = wr_pend_reg && ofs_hit(wr_addr_reg, OFS_KEY);
  wire wr_ist = wr_pend_reg && ofs_hit(wr_addr_reg, OFS_IST);
  wire wr_imsk = wr_pend_reg && ofs_hit(wr_addr_reg, OFS_IMSK);

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  logic unlocked;
  // Locked writes to control are dropped silently
  wire osc_wr_ok = wr_osc && unlocked;

  occ_unlock occ_unlock_inst (
    .clk(CLOCK),
    .rst_n(RST_N),
    .key_wr(wr_key),
    .key_data(HWDATA),
    .consume(wr_osc),
    .unlocked(unlocked)
  );

  // ---------------------------------------------------------------
  // Oscillator control state
  // ---------------------------------------------------------------
  logic cf_reg; // Sticky clock-fail flag
  logic usbfrc_reg; // USB clock from fast RC
  logic sosc_reg; // Secondary oscillator on
  logic swreq_reg; // Switch in progress
  logic [2:0] new_osc_select_reg; // Requested source
  logic [2:0] cosc_reg; // Running source

  // Switch finishes when the oscillator side acknowledges
  wire sw_done = swreq_reg && SWITCH_ACK;
  wire sw_set = osc_wr_ok && HWDATA[OSC_SWREQ_B];
  // Monitor failure flag; software may clear, failure wins
  wire cf_set = CLK_FAIL_DET;

  // Control bits are only taken on an unlocked write
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      usbfrc_reg <= 1'b0;
      sosc_reg <= 1'b0;
      new_osc_select_reg <= CUR_OSC_RST;
    end else if (osc_wr_ok) begin
      usbfrc_reg <= HWDATA[OSC_USBFRC_B];
      sosc_reg <= HWDATA[OSC_SOSC_B];
      new_osc_select_reg <= HWDATA[OSC_NEW_LSB +: SEL_W];
    end
  end

  // Clock-fail flag; set beats a clearing write
  always_ff @(posedge CLOCK) begin
    if (!RST_N) cf_reg <= 1'b0;
    else if (cf_set) cf_reg <= 1'b1;
    else if (osc_wr_ok && !HWDATA[OSC_CF_B]) cf_reg <= 1'b0;
  end

  // Switch request; a new request beats completion
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      swreq_reg <= 1'b0;
      cosc_reg <= CUR_OSC_RST;
    end else begin
      if (sw_set) swreq_reg <= 1'b1;
      else if (sw_done) swreq_reg <= 1'b0;
      if (sw_done) cosc_reg <= new_osc_select_reg;
    end
  end

  assign SWITCH_REQ = swreq_reg;
  assign NEW_OSC = new_osc_select_reg;
  assign SOSC_EN = sosc_reg;
  assign USB_FRC_SEL = usbfrc_reg;

  // ---------------------------------------------------------------
  // Bus clock on the oscillator output pin
  // ---------------------------------------------------------------
  logic pbtog_reg; // Divided bus clock level

  // Half rate of the bus clock tick; crystal modes need the pin
  always_ff @(posedge CLOCK) begin
    if (!RST_N) pbtog_reg <= 1'b0;
    else if (PERIPHERAL_BUS_CLOCK_TICK) pbtog_reg <= ~pbtog_reg;
  end

  assign OSC_OUT_OE = PB_OUT_MODES[cosc_reg];
  assign OSC_OUT = pbtog_reg & OSC_OUT_OE;

  // ---------------------------------------------------------------
  // Reference clock control
  // ---------------------------------------------------------------
  logic [REF_DIV_W-1:0] rdiv_reg; // Divider as written
  logic [REF_DIV_W-1:0] rdiv_act_reg; // Divider in use
  logic [REF_SEL_W-1:0] rsel_reg; // Source select
  logic ron_reg; // Generator enabled
  logic rsidl_reg; // Stop in idle
  logic roe_reg; // Output pin enable
  logic refclk_run_in_sleep_reg; // Run in sleep
  logic dsw_reg; // Divider switch pending

  // Write data with read-only and unused bits masked off
  wire [31:0] rwd = HWDATA & REF_WMASK;
  wire dsw_set = wr_ref && rwd[REF_DSW_B];
  // Off: divider applies at once; on: only on divider switch
  wire dsw_done = dsw_reg || (!ron_reg && wr_ref);

  // Plain fields; writes while active are software's hazard
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      rdiv_reg <= '0;
      rsel_reg <= '0;
      ron_reg <= 1'b0;
      rsidl_reg <= 1'b0;
      roe_reg <= 1'b0;
      refclk_run_in_sleep_reg <= 1'b0;
    end else if (wr_ref) begin
      rdiv_reg <= rwd[REF_DIV_LSB +: REF_DIV_W];
      rsel_reg <= rwd[REF_SEL_LSB +: REF_SEL_W];
      ron_reg <= rwd[REF_ON_B];
      rsidl_reg <= rwd[REF_STOP_WHEN_IDLE_B];
      roe_reg <= rwd[REF_OE_B];
      refclk_run_in_sleep_reg <= rwd[REF_REFCLK_RUN_IN_SLEEP_B];
    end
  end

  // Divider switch bit; a fresh set beats the clear
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      dsw_reg <= 1'b0;
      rdiv_act_reg <= '0;
    end else begin
      if (dsw_set && ron_reg) dsw_reg <= 1'b1;
      else if (dsw_reg) dsw_reg <= 1'b0;
      if (dsw_done) rdiv_act_reg <= wr_ref ? rwd[REF_DIV_LSB +: REF_DIV_W] : rdiv_reg;
    end
  end

  // Run in sleep ignored for the two system-clock sources
  wire sys_src = (rsel_reg < 4'h2);
  wire ref_run = !(IDLE && rsidl_reg) && (!SLEEP || (refclk_run_in_sleep_reg && !sys_src));
  occ_ref_cfg_t ref_cfg;
  assign ref_cfg = '{div: rdiv_act_reg, sel: rsel_reg, on: ron_reg, run: ref_run};
  logic ref_clk;

  occ_refdiv #(
    .NSRC(16)
  ) occ_refdiv_inst (
    .clk(CLOCK),
    .rst_n(RST_N),
    .cfg(ref_cfg),
    .src_tick(REF_SRC_TICK),
    .ref_clk(ref_clk)
  );

  assign REFCLK_OE = roe_reg;
  assign REFCLK_OUT = ref_clk & roe_reg;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] ist_reg; // Sticky events
  logic [IRQ_W-1:0] imsk_reg; // Enables
  logic cf_d_reg; // Previous fail flag
  // Events: divider switch done, switch done, fail flag rise
  wire [IRQ_W-1:0] ev = {dsw_reg, sw_done, cf_reg && !cf_d_reg};
  // Write-one-to-clear bits of the status register
  wire [IRQ_W-1:0] iclr = wr_ist ? HWDATA[IRQ_W-1:0] : '0;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ist_reg <= '0;
      imsk_reg <= '0;
      cf_d_reg <= 1'b0;
    end else begin
      ist_reg <= (ist_reg & ~iclr) | ev;
      cf_d_reg <= cf_reg;
      if (wr_imsk) imsk_reg <= HWDATA[IRQ_W-1:0];
    end
  end

  assign IRQ = |(ist_reg & imsk_reg);

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Offset of the transfer now in its address phase
  wire [7:0] ra = HADDR[7:0];
  // Oscillator control image, high field first
  wire [31:0] osc_rd = {
    17'h0, // Unused, read as zero
    cosc_reg, // Running source, read only
    1'b0,
    new_osc_select_reg, // Requested source
    4'h0,
    cf_reg, // Sticky clock-fail flag
    usbfrc_reg, // USB clock from fast RC
    sosc_reg, // Secondary oscillator on
    swreq_reg // Reads one until the switch is done
  };
  // Active bit mirrors the enable: request live while on
  wire [31:0] ref_rd = {
    1'b0, // Unused, read as zero
    rdiv_reg, // Divider as written, not the one in use
    ron_reg, // Generator on
    1'b0,
    rsidl_reg, // Stop in idle
    roe_reg, // Output pin enable
    refclk_run_in_sleep_reg, // Run in sleep
    1'b0,
    dsw_reg, // Divider switch pending
    ron_reg, // Request active
    4'h0,
    rsel_reg // Source select
  };
  // Unmapped offsets and the key register read as zero
  wire [31:0] rd_mux =
    ofs_hit(ra, OFS_OSC) ? osc_rd :
    ofs_hit(ra, OFS_REF) ? ref_rd :
    ofs_hit(ra, OFS_IST) ? {29'h0, ist_reg} :
    ofs_hit(ra, OFS_IMSK) ? {29'h0, imsk_reg} : 32'h0000_0000;

  // Read data registered at the address phase for the data phase
  always_ff @(posedge CLOCK) begin
    if (!RST_N) HRDATA <= 32'h0000_0000;
    else if (addr_ok && !HWRITE) HRDATA <= rd_mux;
  end

  // ---------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------
  // No wait states: every register answers in one data phase
  assign HREADYOUT = 1'b1;
  // Every access is OKAY; refused writes are simply dropped
  assign HRESP = 1'b0;

endmodule
`default_nettype wire

//--- bench/occ_monitor.sv
// Purpose: Pin and bus relations of the oscillator control block.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to occ_top at the foot of this file.
`timescale 1ns/1ps
`default_nettype none

module occ_monitor
  import occ_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic [31:0] HWDATA,
  input wire logic SWITCH_ACK,
  input wire logic SWITCH_REQ,
  input wire logic SOSC_EN,
  input wire logic USB_FRC_SEL,
  input wire logic OSC_OUT,
  input wire logic OSC_OUT_OE,
  input wire logic REFCLK_OUT,
  input wire logic REFCLK_OE,
  input wire logic IRQ
);
  // ---------------------------------------------------------------
  // Common clocking
  // ---------------------------------------------------------------
  default clocking mon_cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  // ---------------------------------------------------------------
  // Bus answer and switch handshake
  // ---------------------------------------------------------------
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready or not okay");
  a_req_hold: assert property (SWITCH_REQ && !SWITCH_ACK |=> SWITCH_REQ)
    else $error("switch request dropped without ack");
  a_req_clear: assert property (SWITCH_REQ && SWITCH_ACK |=> !SWITCH_REQ)
    else $error("switch request stuck after ack");
  a_req_cause: assert property ($rose(SWITCH_REQ) |-> $past(HWDATA[OSC_SWREQ_B]))
    else $error("switch request without a written one");

  // ---------------------------------------------------------------
  // Control pins follow written data only; clock outputs gated by their enables
  // ---------------------------------------------------------------
  a_sosc_write: assert property ($changed(SOSC_EN) |-> $past(HWDATA[OSC_SOSC_B]) == SOSC_EN)
    else $error("secondary enable moved without a write");
  a_usb_write: assert property ($changed(USB_FRC_SEL) |-> $past(HWDATA[OSC_USBFRC_B]) == USB_FRC_SEL)
    else $error("usb select moved without a write");
  a_refout_gate: assert property (!REFCLK_OE |-> !REFCLK_OUT)
    else $error("reference clock out while disabled");
  a_oscout_gate: assert property (!OSC_OUT_OE |-> !OSC_OUT)
    else $error("bus clock out in a driving mode");

  // Main scenarios reached
  c_switch_done: cover property (SWITCH_REQ && SWITCH_ACK);
  c_ref_toggle: cover property (REFCLK_OE && $changed(REFCLK_OUT));
  c_irq_rise: cover property ($rose(IRQ));
endmodule

bind occ_top occ_monitor occ_monitor_inst (
  .CLOCK(CLOCK), .RST_N(RST_N), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HWDATA(HWDATA),
  .SWITCH_ACK(SWITCH_ACK), .SWITCH_REQ(SWITCH_REQ), .SOSC_EN(SOSC_EN), .USB_FRC_SEL(USB_FRC_SEL),
  .OSC_OUT(OSC_OUT), .OSC_OUT_OE(OSC_OUT_OE), .REFCLK_OUT(REFCLK_OUT), .REFCLK_OE(REFCLK_OE), .IRQ(IRQ)
);
`default_nettype wire

//--- bench/occ_top_tb_top.sv
// Purpose: Self-checking bench for the oscillator control block.
// Assumes: AHB-Lite single word transfers, zero-wait slave.
// Notes:   Sleep and idle held low; size fixed to a word.
`timescale 1ns/1ps
`default_nettype none

module occ_top_tb_top
  import occ_pkg::*;
;
  logic clock = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic fail_det = 1'b0, sw_ack = 1'b0, pb_tick = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [15:0] src_tick = 16'h0000;
  logic hready, hresp, sw_req, sosc_en, usb_sel, osc_out, osc_oe, ref_out, ref_oe, irq;
  logic [2:0] new_osc;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  // ---------------------------------------------------------------
  // Clock, design and hang guard
  // ---------------------------------------------------------------
  always #5 clock = ~clock;

  occ_top occ_top_inst (
    .CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata),
    .CLK_FAIL_DET(fail_det), .SWITCH_ACK(sw_ack), .SWITCH_REQ(sw_req), .NEW_OSC(new_osc),
    .SOSC_EN(sosc_en), .USB_FRC_SEL(usb_sel), .PERIPHERAL_BUS_CLOCK_TICK(pb_tick), .OSC_OUT(osc_out),
    .OSC_OUT_OE(osc_oe), .REF_SRC_TICK(src_tick), .SLEEP(1'b0), .IDLE(1'b0),
    .REFCLK_OUT(ref_out), .REFCLK_OE(ref_oe), .IRQ(irq)
  );

  // Cuts a hang well past the fewer than two hundred cycles needed
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One word transfer; read data taken at the end of its data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  // Counts output edges over n source ticks, one tick every other cycle
  task automatic ticks(input int n, input int exp);
    int cnt;
    logic prev;
    cnt = 0;
    repeat (2) @(posedge clock);
    prev = ref_out;
    repeat (n) begin
      src_tick <= 16'h0001;
      @(posedge clock);
      src_tick <= 16'h0000;
      @(posedge clock);
      if (ref_out !== prev) cnt++;
      prev = ref_out;
    end
    chk(32'(cnt), 32'(exp));
  endtask

  task automatic fail_pulse;
    fail_det <= 1'b1;
    @(posedge clock);
    fail_det <= 1'b0;
    // Status bit lands one edge after the flag itself
    repeat (2) @(posedge clock);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) rdchk(8'(4 * i), 32'h0000_0000);
    chk({sw_req, sosc_en, usb_sel, osc_oe, ref_oe, irq}, 32'h0000_0004);
    chk({hready, hresp}, 32'h0000_0002);
    pb_tick <= 1'b1;
    @(posedge clock);
    pb_tick <= 1'b0;
    @(posedge clock);
    chk(osc_out, 32'h0000_0001);
    $display("reset test done");
    // Fail flag, locked write dropped, interrupt cleared
    xfer(1'b1, OFS_IMSK, 32'h0000_0007);
    fail_pulse();
    chk(irq, 32'h0000_0001);
    rdchk(OFS_OSC, 32'h0000_0008);
    xfer(1'b1, OFS_OSC, 32'h0000_0002);
    rdchk(OFS_OSC, 32'h0000_0008);
    rdchk(OFS_IST, 32'h0000_0001);
    xfer(1'b1, OFS_IST, 32'h0000_0007);
    @(posedge clock);
    chk(irq, 32'h0000_0000);
    $display("fail test done");
    // Unlocked switch to source 3, which claims the output pin
    xfer(1'b1, OFS_KEY, KEY1);
    xfer(1'b1, OFS_KEY, KEY2);
    xfer(1'b1, OFS_OSC, 32'h0000_0307);
    @(posedge clock);
    chk({sw_req, sosc_en, usb_sel, new_osc}, 32'h0000_003B);
    rdchk(OFS_OSC, 32'h0000_0307);
    sw_ack <= 1'b1;
    @(posedge clock);
    sw_ack <= 1'b0;
    @(posedge clock);
    chk({sw_req, osc_oe, osc_out, irq}, 32'h0000_0001);
    rdchk(OFS_OSC, 32'h0000_3306);
    xfer(1'b1, OFS_IST, 32'h0000_0002);
    xfer(1'b1, OFS_IMSK, 32'h0000_0000);
    fail_pulse();
    chk(irq, 32'h0000_0000);
    xfer(1'b1, OFS_IST, 32'h0000_0007);
    $display("switch test done");
    // Reference divider, switch handshake and output enable
    xfer(1'b1, OFS_REF, 32'h0001_9000);
    rdchk(OFS_REF, 32'h0001_9100);
    ticks(8, 8);
    xfer(1'b1, OFS_REF, 32'h0002_9000);
    ticks(8, 8);
    xfer(1'b1, OFS_REF, 32'h0002_9200);
    ticks(8, 4);
    rdchk(OFS_REF, 32'h0002_9100);
    rdchk(OFS_IST, 32'h0000_0004);
    xfer(1'b1, OFS_REF, 32'h0002_8000);
    ticks(8, 0);
    chk(ref_oe, 32'h0000_0000);
    rdchk(8'h20, 32'h0000_0000);
    $display("reference test done");
    wrap_up();
  end
endmodule
`default_nettype wire
